// ### flash_host_ctrl.sv
// Purpose: host controller that sequences commands into a parallel flash
// Assumes: single 100 MHz clock, avalon-mm slave with waitrequest
// Notes:   polls the toggle bit and ready pin to find end of write
`timescale 1ns/1ns
module flash_host_ctrl #(
	parameter int ERASE_CYC = 10000000
) (
	// clock and reset
	input  wire logic                   ref_clk,
	input  wire logic                   rst_b,
	// avalon-mm slave
	input  wire logic [3:0]             avs_address,
	input  wire logic                   avs_read,
	input  wire logic                   avs_write,
	input  wire logic [31:0]            avs_writedata,
	output logic [31:0]                 avs_readdata,
	output logic                        avs_waitrequest,
	// flash pins
	output flash_host_pkg::flash_pins_s flash,
	input  wire logic [15:0]            flash_dq_i,
	output logic                        flash_wp_b,
	input  wire logic                   op_done_flag_od
);
	import flash_host_pkg::*;
	typedef enum logic [5:0] {
		S_IDLE = 6'b000001,
		S_SEQ  = 6'b000010,
		S_POLL = 6'b000100,
		S_CHK  = 6'b001000,
		S_WAIT = 6'b010000,
		S_FIN  = 6'b100000
	} ctl_e;
	ctl_e        state;
	logic [2:0]  op;
	logic [17:0] addr;
	logic [15:0] wdata;
	logic        wp;
	logic        busy;
	logic        done;
	logic        fail;
	logic        susp;
	logic [15:0] rdata;
	logic [2:0]  step;
	logic [2:0]  nsteps;
	logic [15:0] prev;
	logic        have_prev;
	logic [1:0]  retry;
	logic [31:0] tmo;
	logic        rdy_s1;
	logic        rdy_s2;
	logic        bc_start;
	logic        bc_done;
	logic [15:0] bc_rdata;
	flash_cyc_s  bc_cyc;
	logic        bc_busy;

	function automatic flash_cyc_s seq_cyc(input logic [2:0] o,
		input logic [2:0] s, input logic [17:0] a, input logic [15:0] d);
		flash_cyc_s c;
		c = '{addr: ADDR_UNL1, data: CMD_UNL1, wr: 1'b1};
		case (s)
			3'd1, 3'd4: c = '{addr: ADDR_UNL2, data: CMD_UNL2, wr: 1'b1};
			3'd2: c.data = (o == OP_PROG) ? CMD_PROG : CMD_ERASE;
			3'd3: if (o == OP_PROG) c = '{addr: a, data: d, wr: 1'b1};
			3'd5: case (o)
				OP_SECTOR: c = '{addr: a, data: CMD_SECT, wr: 1'b1};
				OP_BLOCK:  c = '{addr: a, data: CMD_BLOCK, wr: 1'b1};
				default:   c.data = CMD_CHIP;
			endcase
			default: c = c;
		endcase
		return c;
	endfunction

	wire [17:0] sect_addr = {addr[17:11], 11'h000};
	wire [17:0] blk_addr  = {addr[17:15], 15'h0000};
	wire [17:0] op_addr   = (op == OP_SECTOR) ? sect_addr :
		(op == OP_BLOCK) ? blk_addr : addr;
	wire single = (op == OP_SUSPEND) || (op == OP_RESUME);
	wire [15:0] single_d = (op == OP_SUSPEND) ? CMD_SUSP : CMD_RES;
	wire is_erase = (op == OP_SECTOR) || (op == OP_BLOCK) ||
		(op == OP_CHIP);
	wire [31:0] op_tmo = (op == OP_PROG) ? 32'(T_PROG_CYC) :
		single ? 32'(T_SUSP_CYC) : 32'(ERASE_CYC);
	// toggle stopped when two reads agree on bit 6
	wire toggling = have_prev && (prev[6] != bc_rdata[6]);
	// polling bit true data once program completes
	wire poll_ok = (op == OP_PROG) ? (bc_rdata[7] == wdata[7]) :
		is_erase ? bc_rdata[7] : 1'b1;
	wire go_write = avs_write && !avs_waitrequest;
	wire acc_ok = (state == S_IDLE) || (avs_address != OFF_CTRL);

	always_ff @(posedge ref_clk) begin
		rdy_s1 <= op_done_flag_od;
		rdy_s2 <= rdy_s1;
	end

	// no new sequence issued until busy clears
	assign avs_waitrequest = (avs_read || avs_write) && !acc_ok;
	assign bc_busy = (state == S_SEQ) || (state == S_POLL) ||
		(state == S_CHK);
	// single write cycle, then status reads
	assign bc_cyc = (state == S_SEQ && single) ?
		flash_cyc_s'{addr: addr, data: single_d, wr: 1'b1} :
		(state == S_SEQ && op != OP_READ) ?
		seq_cyc(op, step, op_addr, wdata) :
		flash_cyc_s'{addr: op_addr, data: 16'h0000, wr: 1'b0};
	// write protect held steady from register
	assign flash_wp_b = wp;

	always_comb begin
		avs_readdata = 32'h0000_0000;
		case (avs_address)
			OFF_CTRL:   avs_readdata = {28'h0, 1'b0, op} |
				(32'(wp) << CTRL_WP);
			OFF_ADDR:   avs_readdata = {14'h0, addr};
			OFF_WDATA:  avs_readdata = {16'h0, wdata};
			OFF_STATUS: avs_readdata = {27'h0, susp, rdy_s2, fail, done,
				busy};
			OFF_RDATA:  avs_readdata = {16'h0, rdata};
			default:    avs_readdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			state     <= S_IDLE;
			op        <= OP_READ;
			addr      <= 18'h00000;
			wdata     <= 16'h0000;
			wp        <= 1'b1;
			busy      <= 1'b0;
			done      <= 1'b0;
			fail      <= 1'b0;
			susp      <= 1'b0;
			rdata     <= 16'h0000;
			step      <= 3'd0;
			nsteps    <= 3'd0;
			prev      <= 16'h0000;
			have_prev <= 1'b0;
			retry     <= 2'd0;
			tmo       <= 32'h0;
			bc_start  <= 1'b0;
		end else begin
			bc_start <= 1'b0;
			if (go_write && avs_address == OFF_ADDR)
				addr <= avs_writedata[17:0];
			if (go_write && avs_address == OFF_WDATA)
				wdata <= avs_writedata[15:0];
			if (go_write && avs_address == OFF_STATUS &&
				avs_writedata[ST_DONE])
				done <= 1'b0;
			case (state)
				S_IDLE: if (go_write && avs_address == OFF_CTRL) begin
					op   <= avs_writedata[CTRL_OP_W-1:0];
					wp   <= avs_writedata[CTRL_WP];
					if (avs_writedata[CTRL_GO]) begin
						busy      <= 1'b1;
						fail      <= 1'b0;
						step      <= 3'd0;
						have_prev <= 1'b0;
						retry     <= 2'd0;
						nsteps    <= (avs_writedata[2:0] == OP_PROG) ? 3'd4 :
							3'd6;
						bc_start  <= 1'b1;
						state     <= S_SEQ;
					end
				end
				S_SEQ: if (bc_done) begin
					if (op == OP_READ) begin
						rdata <= bc_rdata;
						state <= S_FIN;
					end else if (single || step == nsteps - 3'd1) begin
						// status polled only after launch strobe
						tmo      <= op_tmo;
						bc_start <= 1'b1;
						state    <= S_POLL;
						if (op == OP_SUSPEND) susp <= 1'b1;
						if (op == OP_RESUME) susp <= 1'b0;
					end else begin
						step     <= step + 3'd1;
						bc_start <= 1'b1;
					end
				end
				S_POLL: begin
					if (tmo != 32'h0)
						tmo <= tmo - 32'h1;
					if (bc_done) begin
						prev      <= bc_rdata;
						have_prev <= 1'b1;
						// ready pin high and toggle stopped
						if (have_prev && !toggling && rdy_s2) begin
							if (poll_ok || op == OP_SUSPEND) begin
								rdata <= bc_rdata;
								state <= S_FIN;
							end else
								state <= S_CHK;
						end else if (tmo == 32'h0) begin
							fail  <= 1'b1;
							state <= S_FIN;
						end else
							bc_start <= 1'b1;
					end
				end
				S_CHK: begin
					if (retry == 2'(RETRY_READS)) begin
						fail  <= 1'b1;
						state <= S_FIN;
					end else begin
						retry    <= retry + 2'd1;
						bc_start <= 1'b1;
						state    <= S_WAIT;
					end
				end
				S_WAIT: if (bc_done) begin
					if (poll_ok) begin
						rdata <= bc_rdata;
						state <= S_FIN;
					end else
						state <= S_CHK;
				end
				S_FIN: begin
					busy  <= 1'b0;
					done  <= 1'b1;
					state <= S_IDLE;
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	flash_bus_cycle #(
		.STROBE_CYC(T_STROBE_CYC)
	) flash_bus_cycle_i (
		.ref_clk(ref_clk),
		.rst_b  (rst_b),
		.start  (bc_start),
		.cyc    (bc_cyc),
		.done   (bc_done),
		.rdata  (bc_rdata),
		.pins   (flash),
		.dq_i   (flash_dq_i)
	);

	a_busy_done: assert property (@(posedge ref_clk) disable iff (!rst_b)
		state == S_FIN |=> done && !busy)
		else $error("done not raised after finish");
	a_wp_steady: assert property (@(posedge ref_clk) disable iff (!rst_b)
		bc_busy |=> $stable(flash_wp_b))
		else $error("write protect changed mid sequence");
	a_seq_count: assert property (@(posedge ref_clk) disable iff (!rst_b)
		state == S_SEQ |-> step < 3'd6)
		else $error("sequence ran past six cycles");
	a_strobe_pair: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!flash.we_b |-> !flash.ce_b && flash.oe_b)
		else $error("write strobe without chip enable");
	a_oe_read: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!flash.oe_b |-> !flash.dq_oe)
		else $error("bus contention on read");
	a_poll_after: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(state == S_POLL || state == S_WAIT) |-> flash.we_b)
		else $error("write strobe during status poll");
	a_retry_max: assert property (@(posedge ref_clk) disable iff (!rst_b)
		retry <= 2'(RETRY_READS))
		else $error("too many retries");
	a_sect_align: assert property (@(posedge ref_clk) disable iff (!rst_b)
		op == OP_SECTOR |-> op_addr[10:0] == 11'h000)
		else $error("sector address not aligned");
endmodule

// ### flash_host_pkg.sv
// Purpose: shared constants and carriers for the flash host controller
// Assumes: 100 MHz ref_clk, asynchronous x16 parallel NOR flash outside
// Notes:   avalon register map and flash command codes
package flash_host_pkg;
	// avalon register word offsets (byte address / 4)
	localparam logic [3:0] OFF_CTRL   = 4'h0;
	localparam logic [3:0] OFF_ADDR   = 4'h1;
	localparam logic [3:0] OFF_WDATA  = 4'h2;
	localparam logic [3:0] OFF_STATUS = 4'h3;
	localparam logic [3:0] OFF_RDATA  = 4'h4;
	// ctrl fields
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_OP_W   = 3;
	localparam int CTRL_GO     = 31;
	localparam int CTRL_WP     = 8;
	// status fields
	localparam int ST_BUSY     = 0;
	localparam int ST_DONE     = 1;
	localparam int ST_FAIL     = 2;
	localparam int ST_RDY_PIN  = 3;
	localparam int ST_SUSP     = 4;
	// operations
	localparam logic [2:0] OP_READ    = 3'h0;
	localparam logic [2:0] OP_PROG    = 3'h1;
	localparam logic [2:0] OP_SECTOR  = 3'h2;
	localparam logic [2:0] OP_BLOCK   = 3'h3;
	localparam logic [2:0] OP_CHIP    = 3'h4;
	localparam logic [2:0] OP_SUSPEND = 3'h5;
	localparam logic [2:0] OP_RESUME  = 3'h6;
	// command codes and unlock addresses
	localparam logic [17:0] ADDR_UNL1 = 18'h00555;
	localparam logic [17:0] ADDR_UNL2 = 18'h002aa;
	localparam logic [15:0] CMD_UNL1  = 16'h00aa;
	localparam logic [15:0] CMD_UNL2  = 16'h0055;
	localparam logic [15:0] CMD_PROG  = 16'h00a0;
	localparam logic [15:0] CMD_ERASE = 16'h0080;
	localparam logic [15:0] CMD_SECT  = 16'h0050;
	localparam logic [15:0] CMD_BLOCK = 16'h0030;
	localparam logic [15:0] CMD_CHIP  = 16'h0010;
	localparam logic [15:0] CMD_SUSP  = 16'h00b0;
	localparam logic [15:0] CMD_RES   = 16'h0030;
	localparam logic [15:0] CMD_RESET = 16'h00f0;
	// timing
	localparam int CLK_MHZ      = 100;
	localparam int T_STROBE_NS  = 60;
	localparam int T_STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int T_PROG_US    = 10;
	localparam int T_PROG_CYC   = T_PROG_US * CLK_MHZ;
	localparam int T_SUSP_US    = 20;
	localparam int T_SUSP_CYC   = T_SUSP_US * CLK_MHZ;
	localparam int T_ERASE_US   = 100000;
	localparam int RETRY_READS  = 2;
	// one bus cycle on the flash pins
	typedef struct packed {
		logic [17:0] addr;
		logic [15:0] data;
		logic        wr;
	} flash_cyc_s;
	// flash pin drive
	typedef struct packed {
		logic        ce_b;
		logic        oe_b;
		logic        we_b;
		logic [17:0] addr;
		logic [15:0] dq_o;
		logic        dq_oe;
	} flash_pins_s;
endpackage

// ### flash_bus_cycle.sv
// Purpose: one strobed read or write cycle on the flash pins
// Assumes: ce_b and we_b fall together, data held past rising edge
// Notes:   dq_i is sampled through two flops before use
`timescale 1ns/1ns
module flash_bus_cycle #(
	parameter int STROBE_CYC = 6
) (
	// clock and reset
	input  wire logic                      ref_clk,
	input  wire logic                      rst_b,
	// request
	input  wire logic                      start,
	input  wire flash_host_pkg::flash_cyc_s cyc,
	output logic                           done,
	output logic [15:0]                    rdata,
	// pins
	output flash_host_pkg::flash_pins_s    pins,
	input  wire logic [15:0]               dq_i
);
	import flash_host_pkg::*;
	typedef enum logic [2:0] {
		C_IDLE = 3'b001,
		C_STRB = 3'b010,
		C_HOLD = 3'b100
	} cyc_e;
	cyc_e        state;
	logic [7:0]  cnt;
	logic [15:0] dq_s1;
	logic [15:0] dq_s2;
	flash_cyc_s  cur;
	wire         cnt_end = (cnt == 8'(STROBE_CYC - 1));
	always_ff @(posedge ref_clk) begin
		dq_s1 <= dq_i;
		dq_s2 <= dq_s1;
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			state <= C_IDLE;
			cnt   <= 8'h00;
			cur   <= '0;
			done  <= 1'b0;
			rdata <= 16'h0000;
		end else begin
			done <= 1'b0;
			case (state)
				C_IDLE: if (start) begin
					cur   <= cyc;
					cnt   <= 8'h00;
					state <= C_STRB;
				end
				C_STRB: begin
					cnt <= cnt + 8'h01;
					if (cnt_end) begin
						rdata <= dq_s2;
						cnt   <= 8'h00;
						state <= C_HOLD;
					end
				end
				C_HOLD: begin
					done  <= 1'b1;
					state <= C_IDLE;
				end
				default: state <= C_IDLE;
			endcase
		end
	end
	// strobes low together, data latched at rise
	assign pins.ce_b  = (state != C_STRB);
	assign pins.we_b  = !(state == C_STRB && cur.wr);
	assign pins.oe_b  = !(state == C_STRB && !cur.wr);
	assign pins.addr  = cur.addr;
	assign pins.dq_o  = cur.data;
	assign pins.dq_oe = cur.wr && (state != C_IDLE);
endmodule

// ### flash_dev_model.sv
// Purpose: behavioural x16 parallel flash answering the host controller
// Assumes: host changes pins from clocked logic, strobes held >= 60 ns
// Notes:   short internal timers; array starts erased
`timescale 1ns/1ns
module flash_dev_model #(
	parameter int PROG_CYC  = 300,
	parameter int ERASE_CYC = 500
) (
	// timer clock
	input  wire logic        ref_clk,
	// host pins
	input  wire logic        ce_b,
	input  wire logic        oe_b,
	input  wire logic        we_b,
	input  wire logic [17:0] addr,
	input  wire logic [15:0] dq_o,
	input  wire logic        wp_b,
	// device outputs
	output logic      [15:0] dq_i,
	output logic             op_done_flag_od
);
	logic [15:0] mem [0:262143];
	logic [15:0] pd;
	logic [15:0] last;
	logic [15:0] rd;
	logic        erasing;
	logic        tog;
	int          step;
	int          now_cyc = 0;
	int          end_cyc = 0;
	localparam logic [4:0] BOOT_SEL = 5'h00;
	// write latched at the earlier rise of the two strobes
	wire         wr_act   = !we_b && !ce_b;
	wire         busy     = now_cyc < end_cyc;
	wire         boot_hit = !wp_b && addr[17:13] == BOOT_SEL;
	initial begin
		for (int i = 0; i < 262144; i++) mem[i] = 16'hffff;
		step = 0;
		erasing = 1'b0;
		tog = 1'b0;
		pd = 16'h0000;
		last = 16'h0000;
	end
	always @(negedge wr_act) begin
		if (!busy) begin
			case (step)
			0, 5: step = (addr == 18'h00555 && dq_o[7:0] == 8'haa) ? step + 1 : 0;
			1, 6: step = (addr == 18'h002aa && dq_o[7:0] == 8'h55) ? step + 1 : 0;
			2: step = dq_o[7:0] == 8'ha0 ? 3 : (dq_o[7:0] == 8'h80 ? 5 : 0);
			3: begin
				pd = mem[addr] & dq_o;
				mem[addr] = pd;
				erasing = 1'b0;
				end_cyc = now_cyc + PROG_CYC;
				step = 0;
			end
			7: begin
				step = 0;
				erasing = 1'b1;
				// sector or block erase skipped while write protect low and addr in boot block
				if (dq_o[7:0] == 8'h50 && !boot_hit) begin
					for (int i = 0; i < 2048; i++) mem[{addr[17:11], 11'h0} + i] = 16'hffff;
					end_cyc = now_cyc + ERASE_CYC;
				end else if (dq_o[7:0] == 8'h30 && !boot_hit) begin
					for (int i = 0; i < 32768; i++) mem[{addr[17:15], 15'h0} + i] = 16'hffff;
					end_cyc = now_cyc + ERASE_CYC;
				end else if (dq_o[7:0] == 8'h10 && addr == 18'h00555 && wp_b) begin
					for (int i = 0; i < 262144; i++) mem[i] = 16'hffff;
					end_cyc = now_cyc + ERASE_CYC;
				end
			end
			default: step = 0;
			endcase
		end
	end
	always @(posedge ref_clk) now_cyc <= now_cyc + 1;
	// toggle bit flips on each read while busy
	always @(posedge oe_b) begin
		last = rd;
		if (busy) tog = ~tog;
	end
	// status replaces data while busy, no added delay
	assign rd = !busy ? mem[addr] : (erasing ? {8'h00, 1'b0, tog, 6'h00}
		: {pd[15:8], ~pd[7], tog, pd[5:0]});
	// released bus shows inverse of last value
	assign dq_i = (!ce_b && !oe_b) ? rd : ~last;
	// pulled low while busy, pull-up otherwise
	assign op_done_flag_od = !busy;
endmodule

// ### nor_flash_command_engine_test.sv
// Purpose: self-checking bench for the flash host controller
// Assumes: avalon master tasks, flash model on the pins
// Notes:   ops from a table, then stall and reset cases
`timescale 1ns/1ns
module nor_flash_command_engine_test;
	import flash_host_pkg::*;
	typedef struct packed {
		logic [2:0]  op;
		logic [17:0] a;
		logic [15:0] d;
		logic [15:0] exp;
		logic        wp;
		logic [3:0]  st;
	} row_s;
	logic        ref_clk;
	logic        rst_b;
	logic [3:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	flash_pins_s flash;
	logic [15:0] flash_dq_i;
	logic        flash_wp_b;
	logic        op_done_flag_od;
	logic [31:0] q;
	int          fail_count;
	int          compares;
	int          waits;
	logic [3:0]  st_seen;
	row_s        rows [11];
	flash_host_ctrl #(.ERASE_CYC(2000)) flash_host_ctrl_i (
		.ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .flash(flash),
		.flash_dq_i(flash_dq_i), .flash_wp_b(flash_wp_b),
		.op_done_flag_od(op_done_flag_od));
	flash_dev_model flash_dev_model_i (
		.ref_clk(ref_clk), .ce_b(flash.ce_b), .oe_b(flash.oe_b),
		.we_b(flash.we_b), .addr(flash.addr), .dq_o(flash.dq_o),
		.wp_b(flash_wp_b), .dq_i(flash_dq_i),
		.op_done_flag_od(op_done_flag_od));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		$display("counts: compares=%0d fails=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		waits = 0;
		do begin
			@(posedge ref_clk);
			waits++;
		end while (avs_waitrequest !== 1'b0 && waits < 20000);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge ref_clk);
		if (waits >= 20000) begin
			fail_count++;
			wrap_up();
		end
	endtask
	task automatic run_op(input logic [2:0] op, input logic [17:0] a,
		input logic [15:0] d, input logic wp);
		bus(1'b1, OFF_ADDR, {14'h0, a});
		bus(1'b1, OFF_WDATA, {16'h0, d});
		bus(1'b1, OFF_CTRL, {1'b1, 22'h0, wp, 5'h0, op});
		for (int i = 0; i < 5000; i++) begin
			bus(1'b0, OFF_STATUS, 32'h0);
			if (q[ST_BUSY] === 1'b0) break;
			if (i == 4999) begin
				fail_count++;
				wrap_up();
			end
		end
	endtask
	initial begin
		fail_count = 0;
		compares = 0;
		rst_b = 1'b0;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		rows[0]  = {OP_PROG, 18'h01234, 16'h5a5a, 16'h5a5a, 1'b1, 4'h5};
		rows[1]  = {OP_PROG, 18'h20010, 16'h1234, 16'h1234, 1'b1, 4'h5};
		rows[2]  = {OP_SECTOR, 18'h01234, 16'h0000, 16'hffff, 1'b1, 4'h5};
		rows[3]  = {OP_BLOCK, 18'h20010, 16'h0000, 16'hffff, 1'b1, 4'h5};
		rows[4]  = {OP_PROG, 18'h30000, 16'h0f0f, 16'h0f0f, 1'b1, 4'h5};
		rows[5]  = {OP_CHIP, 18'h30000, 16'h0000, 16'hffff, 1'b1, 4'h5};
		rows[6]  = {OP_PROG, 18'h00000, 16'h0055, 16'h0055, 1'b1, 4'h5};
		// protected erase ignored, data kept, failure reported
		rows[7]  = {OP_CHIP, 18'h00000, 16'h0000, 16'h0055, 1'b0, 4'h7};
		rows[8]  = {OP_SECTOR, 18'h00000, 16'h0000, 16'h0055, 1'b0, 4'h7};
		// suspend flag set, then cleared by resume
		rows[9]  = {OP_SUSPEND, 18'h00000, 16'h0000, 16'h0055, 1'b1, 4'hd};
		rows[10] = {OP_RESUME, 18'h00000, 16'h0000, 16'h0055, 1'b1, 4'h5};
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		chk({31'h0, flash_wp_b}, 32'h1);
		chk({29'h0, flash.ce_b, flash.oe_b, flash.we_b}, 32'h7);
		foreach (rows[i]) begin
			run_op(rows[i].op, rows[i].a, rows[i].d, rows[i].wp);
			st_seen = {q[ST_SUSP], q[ST_RDY_PIN], q[ST_FAIL], q[ST_DONE]};
			chk(32'(st_seen), 32'(rows[i].st));
			bus(1'b1, OFF_STATUS, 32'h2);
			run_op(OP_READ, rows[i].a, 16'h0, 1'b1);
			bus(1'b0, OFF_RDATA, 32'h0);
			chk({16'h0, q[15:0]}, {16'h0, rows[i].exp});
			$display("row %0d done", i);
		end
		// an erase keeps control stalled until the end of write
		bus(1'b1, OFF_ADDR, 32'h08000);
		bus(1'b1, OFF_CTRL, {1'b1, 28'h0, OP_SECTOR});
		bus(1'b0, OFF_CTRL, 32'h0);
		chk({31'h0, waits > 400}, 32'h1);
		$display("stall test done");
		// reset in mid operation returns pins to idle
		bus(1'b1, OFF_CTRL, {1'b1, 28'h0, OP_PROG});
		repeat (3) @(posedge ref_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		chk({29'h0, flash.ce_b, flash.we_b, flash.dq_oe}, 32'h6);
		bus(1'b0, OFF_STATUS, 32'h0);
		chk(q, 32'h8);
		$display("reset test done");
		wrap_up();
	end
endmodule
